// ### rtl/caf_operand_unit.sv
// Operand addressing, branch targets and condition flags of an 8-bit core.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`include "caf_map.svh"
`default_nettype none

// Functional notes
// RULE1: Memory is bytes at 16-bit addresses, 65,536 in all.
// RULE2: Instructions of one to three bytes fetch from consecutive addresses.
// RULE3: Multi-byte memory operands go lowest byte first at consecutive addresses.
// RULE4: Direct operand address is byte 3 high and byte 2 low.
// RULE5: Indirect operand address uses pair first register high, second low.
// RULE6: Immediate data is one byte, or two bytes low first.
// RULE7: Program counter advances past each fetched instruction.
// RULE8: Direct jump target is byte 3 high and byte 2 low.
// RULE9: Indirect jump target comes from a pair, first register high.
// RULE10: Restart call jumps to eight times its three-bit field.
// RULE11: Restart field 000 to 111 means restart zero to seven.
// RULE12: Five one-bit flags; set writes one, reset writes zero.
// RULE13: Zero flag set when the result is zero.
// RULE14: Sign flag copies the result's top bit.
// RULE15: Parity flag set when the result has even parity.
// RULE16: Carry flag set on carry out or borrow out of bit 7.
// RULE17: Aux carry set on carry from bit 3 into bit 4.
// RULE18: Register field 111 is A, 000 to 101 are B to L.
// RULE19: Pair field 00 B-C, 01 D-E, 10 H-L, 11 stack pointer.
// RULE20: In a pair the first register is the high byte.
// RULE21: Program counter and stack pointer are 16 bits with byte halves.
// RULE22: Data bytes are bits 7 down to 0, bit 7 most significant.
module caf_operand_unit
  import caf_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output caf_mem_req_type MEM_REQ,
  input wire logic [7:0] MEM_RDATA
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  caf_state_type state_reg;
  caf_ctrl_type ctrl_reg;
  caf_flags_type flags_reg;
  caf_flags_type flags_next;
  caf_mem_req_type mem_req_reg;
  logic [7:0] regs [0:7];
  logic [7:0] reg_wd [0:7];
  logic [7:0] reg_we;
  logic [7:0] instr_reg [0:2];
  logic [15:0] pc_reg, sp_reg, base_reg;
  logic [1:0] idx_reg, last_reg;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [7:0] waddr_al;
  logic do_write, busy, wr_en, start, cap, cap_last, exec;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [15:0] pair_val, addr_sel;
  logic [7:0] store_byte;
  logic [7:0] alu_a, alu_b, alu_res;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic cin;
  logic [2:0] pair_hi, pair_lo;
  logic [2:0] restart_number_field;

  // Applies the byte strobes of a bus write to an old register word.
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // ---------------------------------------------------------------------------
  // Shared decode terms
  // ---------------------------------------------------------------------------
  // Bus writes land only while the sequencer is idle; a control write starts it.
  assign busy = (state_reg != ST_IDLE);
  assign do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;
  assign waddr_al = {waddr_reg[7:2], 2'b00};
  assign wr_en = do_write & ~busy;
  assign start = wr_en & (waddr_al == `CAF_OFF_CTRL);
  assign exec = (state_reg == ST_EXEC);
  assign cap = (state_reg == ST_CAP);
  assign cap_last = cap & (idx_reg == last_reg);
  assign pair_hi = {ctrl_reg.pair, 1'b0};
  assign pair_lo = {ctrl_reg.pair, 1'b1};
  // RULE11: restart field taken
  assign restart_number_field = instr_reg[0][`CAF_RST_HI:`CAF_RST_LO];

  // Pair value selected by the pair field, first register high.
  always_comb begin
    // RULE19: pair decode
    // RULE20: first register high
    case (ctrl_reg.pair)
      2'h0: pair_val = {regs[`CAF_IDX_B], regs[`CAF_IDX_C]};
      2'h1: pair_val = {regs[`CAF_IDX_D], regs[`CAF_IDX_E]};
      2'h2: pair_val = {regs[`CAF_IDX_H], regs[`CAF_IDX_L]};
      default: pair_val = sp_reg;
    endcase
  end

  // Operand address: a pair for narrow indirect transfers, else bytes 2 and 3.
  always_comb begin
    // RULE5: indirect operand address
    if (ctrl_reg.mode == MODE_INDIRECT && !ctrl_reg.wide) begin
      addr_sel = pair_val;
    end else begin
      // RULE4: direct operand address
      addr_sel = {instr_reg[2], instr_reg[1]};
    end
  end

  // Byte offered on a store: one register, or a pair low byte then high byte.
  always_comb begin
    if (!ctrl_reg.wide) begin
      store_byte = regs[ctrl_reg.regf];
    end else if (idx_reg == 2'h0) begin
      // RULE3: low byte first
      store_byte = pair_val[7:0];
    end else begin
      store_byte = pair_val[15:8];
    end
  end

  // ---------------------------------------------------------------------------
  // Arithmetic and flags
  // ---------------------------------------------------------------------------
  // Accumulator operation with a register or immediate operand.
  always_comb begin
    alu_a = regs[`CAF_IDX_A];
    alu_b = (ctrl_reg.mode == MODE_REGISTER) ? regs[ctrl_reg.regf] : instr_reg[1];
    cin = (ctrl_reg.op == ALU_ADC || ctrl_reg.op == ALU_SBB) ? flags_reg.carry : 1'b0;
    sum9 = 9'h000;
    nib5 = 5'h00;
    case (ctrl_reg.op)
      ALU_ADD, ALU_ADC: begin
        sum9 = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, cin};
        nib5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cin};
      end
      ALU_SUB, ALU_SBB, ALU_CMP: begin
        sum9 = {1'b0, alu_a} - {1'b0, alu_b} - {8'h00, cin};
        nib5 = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + {4'h0, ~cin};
      end
      ALU_AND: sum9 = {1'b0, alu_a & alu_b};
      ALU_XOR: sum9 = {1'b0, alu_a ^ alu_b};
      ALU_OR: sum9 = {1'b0, alu_a | alu_b};
      default: sum9 = 9'h000;
    endcase
    alu_res = sum9[7:0];
    // RULE13: zero on zero result
    flags_next.zero = (alu_res == 8'h00);
    // RULE14: sign from bit 7
    // RULE22: bit 7 most significant
    flags_next.sign = alu_res[`CAF_MSB];
    // RULE15: even parity sets
    flags_next.parity = ~^alu_res;
    // RULE16: carry or borrow out
    flags_next.carry = sum9[`CAF_BYTE_CARRY];
    // RULE17: carry into bit 4
    flags_next.aux = nib5[`CAF_NIB_CARRY];
  end

  // Flag register: written by software or by an arithmetic command.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      flags_reg <= `CAF_RESET_FLAGS;
    end else if (wr_en && waddr_al == `CAF_OFF_STATUS) begin
      // RULE12: set writes one
      flags_reg <= caf_flags_type'(5'(merge({27'h0, flags_reg}, wdata_reg, wstrb_reg)));
    end else if (exec && ctrl_reg.cmd == CMD_ALU) begin
      flags_reg <= flags_next;
    end
  end

  // ---------------------------------------------------------------------------
  // General register file
  // ---------------------------------------------------------------------------
  // Write enables and data for each register entry.
  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    reg_we = 8'h00;
    reg_wd = '{default: 8'h00};
    if (wr_en && waddr_al == `CAF_OFF_BCDE) begin
      m = merge({regs[`CAF_IDX_B], regs[`CAF_IDX_C], regs[`CAF_IDX_D], regs[`CAF_IDX_E]},
                wdata_reg, wstrb_reg);
      reg_we[`CAF_IDX_B] = 1'b1;
      reg_wd[`CAF_IDX_B] = m[31:24];
      reg_we[`CAF_IDX_C] = 1'b1;
      reg_wd[`CAF_IDX_C] = m[23:16];
      reg_we[`CAF_IDX_D] = 1'b1;
      reg_wd[`CAF_IDX_D] = m[15:8];
      reg_we[`CAF_IDX_E] = 1'b1;
      reg_wd[`CAF_IDX_E] = m[7:0];
    end
    if (wr_en && waddr_al == `CAF_OFF_AHL) begin
      m = merge({8'h00, regs[`CAF_IDX_A], regs[`CAF_IDX_H], regs[`CAF_IDX_L]},
                wdata_reg, wstrb_reg);
      reg_we[`CAF_IDX_A] = 1'b1;
      reg_wd[`CAF_IDX_A] = m[23:16];
      reg_we[`CAF_IDX_H] = 1'b1;
      reg_wd[`CAF_IDX_H] = m[15:8];
      reg_we[`CAF_IDX_L] = 1'b1;
      reg_wd[`CAF_IDX_L] = m[7:0];
    end
    if (cap && ctrl_reg.cmd == CMD_LOAD) begin
      if (!ctrl_reg.wide) begin
        // RULE18: register field decode
        reg_we[ctrl_reg.regf] = 1'b1;
        reg_wd[ctrl_reg.regf] = MEM_RDATA;
      end else if (ctrl_reg.pair != `CAF_PAIR_SP) begin
        // RULE3: first byte is low
        reg_we[(idx_reg == 2'h0) ? pair_lo : pair_hi] = 1'b1;
        reg_wd[(idx_reg == 2'h0) ? pair_lo : pair_hi] = MEM_RDATA;
      end
    end
    if (exec && ctrl_reg.cmd == CMD_LDIMM) begin
      // RULE6: immediate low byte first
      if (!ctrl_reg.wide) begin
        reg_we[ctrl_reg.regf] = 1'b1;
        reg_wd[ctrl_reg.regf] = instr_reg[1];
      end else if (ctrl_reg.pair != `CAF_PAIR_SP) begin
        reg_we[pair_lo] = 1'b1;
        reg_wd[pair_lo] = instr_reg[1];
        reg_we[pair_hi] = 1'b1;
        reg_wd[pair_hi] = instr_reg[2];
      end
    end
    if (exec && ctrl_reg.cmd == CMD_ALU && ctrl_reg.op != ALU_CMP) begin
      reg_we[`CAF_IDX_A] = 1'b1;
      reg_wd[`CAF_IDX_A] = alu_res;
    end
    reg_we[`CAF_IDX_NONE] = 1'b0;
  end

  // One byte register per field code; code 110 names no register.
  for (genvar i = 0; i < 8; i++) begin : g_regs
    logic [7:0] byte_reg;
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        byte_reg <= `CAF_RESET_BYTE;
      end else if (reg_we[i]) begin
        byte_reg <= reg_wd[i];
      end
    end
    assign regs[i] = byte_reg;
  end

  // ---------------------------------------------------------------------------
  // Program counter, stack pointer and instruction bytes
  // ---------------------------------------------------------------------------
  // Program counter: bus write, advance after a fetch, or branch.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pc_reg <= `CAF_RESET_WORD;
    end else if (wr_en && waddr_al == `CAF_OFF_PC) begin
      // RULE21: sixteen-bit counter
      pc_reg <= 16'(merge({16'h0000, pc_reg}, wdata_reg, wstrb_reg));
    end else if (cap_last && ctrl_reg.cmd == CMD_FETCH) begin
      // RULE7: step past instruction
      pc_reg <= pc_reg + {14'h0000, last_reg} + 16'h0001;
    end else if (exec && ctrl_reg.cmd == CMD_JUMP) begin
      case (ctrl_reg.mode)
        // RULE9: indirect jump target
        MODE_INDIRECT: pc_reg <= pair_val;
        // RULE10: restart target
        MODE_IMMED: pc_reg <= `CAF_RST_STRIDE * {13'h0000, restart_number_field};
        // RULE8: direct jump target
        default: pc_reg <= {instr_reg[2], instr_reg[1]};
      endcase
    end
  end

  // Stack pointer: bus write, wide load into pair 11, or immediate load.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sp_reg <= `CAF_RESET_WORD;
    end else if (wr_en && waddr_al == `CAF_OFF_SP) begin
      sp_reg <= 16'(merge({16'h0000, sp_reg}, wdata_reg, wstrb_reg));
    end else if (cap && ctrl_reg.cmd == CMD_LOAD && ctrl_reg.wide
                 && ctrl_reg.pair == `CAF_PAIR_SP) begin
      // RULE21: halves written apart
      if (idx_reg == 2'h0) begin
        sp_reg[7:0] <= MEM_RDATA;
      end else begin
        sp_reg[15:8] <= MEM_RDATA;
      end
    end else if (exec && ctrl_reg.cmd == CMD_LDIMM && ctrl_reg.wide
                 && ctrl_reg.pair == `CAF_PAIR_SP) begin
      sp_reg <= {instr_reg[2], instr_reg[1]};
    end
  end

  // Instruction bytes: written by software or filled by a fetch.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      instr_reg <= '{default: `CAF_RESET_BYTE};
    end else if (wr_en && waddr_al == `CAF_OFF_INSTR) begin
      for (int i = 0; i < 3; i++) begin
        if (wstrb_reg[i]) begin
          instr_reg[i] <= wdata_reg[i*8 +: 8];
        end
      end
    end else if (cap && ctrl_reg.cmd == CMD_FETCH) begin
      // RULE2: consecutive instruction bytes
      instr_reg[idx_reg] <= MEM_RDATA;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer and memory port
  // ---------------------------------------------------------------------------
  // Walks the bytes of a fetch, load or store one memory access at a time.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= ST_IDLE;
      ctrl_reg <= `CAF_RESET_CTRL;
      idx_reg <= 2'h0;
      last_reg <= 2'h0;
      base_reg <= `CAF_RESET_WORD;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            ctrl_reg <= caf_ctrl_type'(merge(ctrl_reg, wdata_reg, wstrb_reg));
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          idx_reg <= 2'h0;
          case (ctrl_reg.cmd)
            CMD_FETCH: begin
              base_reg <= pc_reg;
              last_reg <= (ctrl_reg.len == 2'h0) ? 2'h0 : 2'(ctrl_reg.len - 2'h1);
              state_reg <= ST_MEM;
            end
            CMD_LOAD, CMD_STORE: begin
              base_reg <= addr_sel;
              last_reg <= ctrl_reg.wide ? 2'h1 : 2'h0;
              state_reg <= ST_MEM;
            end
            default: state_reg <= ST_IDLE;
          endcase
        end
        ST_MEM: begin
          if (ctrl_reg.cmd != CMD_STORE) begin
            state_reg <= ST_WAIT;
          end else if (idx_reg == last_reg) begin
            state_reg <= ST_IDLE;
          end else begin
            idx_reg <= idx_reg + 2'h1;
          end
        end
        ST_WAIT: state_reg <= ST_CAP;
        ST_CAP: begin
          if (idx_reg == last_reg) begin
            state_reg <= ST_IDLE;
          end else begin
            idx_reg <= idx_reg + 2'h1;
            state_reg <= ST_MEM;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Memory requests: one-cycle strobes at base plus byte index.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mem_req_reg <= '0;
    end else begin
      // RULE1: sixteen-bit byte address
      // RULE3: consecutive addresses
      mem_req_reg.addr <= base_reg + {14'h0000, idx_reg};
      mem_req_reg.wdata <= store_byte;
      mem_req_reg.rd <= (state_reg == ST_MEM) && (ctrl_reg.cmd != CMD_STORE);
      mem_req_reg.wr <= (state_reg == ST_MEM) && (ctrl_reg.cmd == CMD_STORE);
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  // Read data selection by the read address.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case ({S_AXI_ARADDR[7:2], 2'b00})
      `CAF_OFF_CTRL: rd_word = ctrl_reg;
      `CAF_OFF_STATUS: begin
        rd_word[4:0] = flags_reg;
        rd_word[`CAF_STAT_BUSY] = busy;
      end
      `CAF_OFF_INSTR: rd_word = {8'h00, instr_reg[2], instr_reg[1], instr_reg[0]};
      `CAF_OFF_PC: rd_word = {16'h0000, pc_reg};
      `CAF_OFF_SP: rd_word = {16'h0000, sp_reg};
      `CAF_OFF_BCDE: rd_word = {regs[`CAF_IDX_B], regs[`CAF_IDX_C],
                                regs[`CAF_IDX_D], regs[`CAF_IDX_E]};
      `CAF_OFF_AHL: rd_word = {8'h00, regs[`CAF_IDX_A], regs[`CAF_IDX_H], regs[`CAF_IDX_L]};
      `CAF_OFF_OPADDR: rd_word = {16'h0000, base_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  // Write channels: address and data taken in either order, then answered.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CAF_RESP_OKAY;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && awready_reg) begin
        waddr_reg <= S_AXI_AWADDR;
        awready_reg <= 1'b0;
      end
      if (S_AXI_WVALID && wready_reg) begin
        wdata_reg <= S_AXI_WDATA;
        wstrb_reg <= S_AXI_WSTRB;
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (busy || waddr_reg >= `CAF_OFF_END) ? `CAF_RESP_SLVERR : `CAF_RESP_OKAY;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel: data answered one cycle after the address is taken.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= `CAF_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (S_AXI_ARVALID && arready_reg) begin
      rdata_reg <= rd_word;
      rresp_reg <= rd_ok ? `CAF_RESP_OKAY : `CAF_RESP_SLVERR;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Output ports straight from their flip-flops.
  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign MEM_REQ = mem_req_reg;

endmodule : caf_operand_unit
`default_nettype wire

// ### rtl/caf_map.svh
// Register map, field positions and reset values of the operand and flag unit.
`ifndef CAF_MAP_SVH
`define CAF_MAP_SVH

// -----------------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// -----------------------------------------------------------------------------
`define CAF_OFF_CTRL 8'h00
`define CAF_OFF_STATUS 8'h04
`define CAF_OFF_INSTR 8'h08
`define CAF_OFF_PC 8'h0C
`define CAF_OFF_SP 8'h10
`define CAF_OFF_BCDE 8'h14
`define CAF_OFF_AHL 8'h18
`define CAF_OFF_OPADDR 8'h1C
`define CAF_OFF_END 8'h20

// -----------------------------------------------------------------------------
// Bus answers and status bit positions
// -----------------------------------------------------------------------------
`define CAF_RESP_OKAY 2'h0
`define CAF_RESP_SLVERR 2'h2
`define CAF_STAT_BUSY 8

// -----------------------------------------------------------------------------
// Register field codes and pair codes
// -----------------------------------------------------------------------------
`define CAF_IDX_B 3'h0
`define CAF_IDX_C 3'h1
`define CAF_IDX_D 3'h2
`define CAF_IDX_E 3'h3
`define CAF_IDX_H 3'h4
`define CAF_IDX_L 3'h5
`define CAF_IDX_NONE 3'h6
`define CAF_IDX_A 3'h7
`define CAF_PAIR_SP 2'h3

// -----------------------------------------------------------------------------
// Instruction fields, arithmetic bit positions and reset values
// -----------------------------------------------------------------------------
`define CAF_RST_HI 5
`define CAF_RST_LO 3
`define CAF_RST_STRIDE 16'h0008
`define CAF_MSB 7
`define CAF_NIB_CARRY 4
`define CAF_BYTE_CARRY 8
`define CAF_RESET_BYTE 8'h00
`define CAF_RESET_WORD 16'h0000
`define CAF_RESET_FLAGS 5'h00
`define CAF_RESET_CTRL 32'h0000_0000

`endif

// ### rtl/caf_pkg.sv
// Types shared by the operand and flag unit.
`default_nettype none
package caf_pkg;

  // Commands that software starts through the control register.
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0, CMD_FETCH = 3'h1, CMD_LOAD = 3'h2, CMD_STORE = 3'h3,
    CMD_LDIMM = 3'h4, CMD_JUMP = 3'h5, CMD_ALU = 3'h6, CMD_RSVD = 3'h7
  } caf_cmd_type;

  // Addressing modes; for a jump the immediate code selects the restart call.
  typedef enum logic [1:0] {
    MODE_DIRECT = 2'h0, MODE_INDIRECT = 2'h1, MODE_IMMED = 2'h2, MODE_REGISTER = 2'h3
  } caf_mode_type;

  // Arithmetic and logic operations on the accumulator.
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_ADC = 3'h1, ALU_SUB = 3'h2, ALU_SBB = 3'h3,
    ALU_AND = 3'h4, ALU_XOR = 3'h5, ALU_OR = 3'h6, ALU_CMP = 3'h7
  } caf_alu_type;

  // Control register layout.
  typedef struct packed {
    logic [15:0] spare;
    logic wide;
    logic [1:0] len;
    caf_alu_type op;
    logic [1:0] pair;
    logic [2:0] regf;
    caf_mode_type mode;
    caf_cmd_type cmd;
  } caf_ctrl_type;

  // The five condition flags.
  typedef struct packed {
    logic sign;
    logic zero;
    logic aux;
    logic parity;
    logic carry;
  } caf_flags_type;

  // One request on the memory port.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } caf_mem_req_type;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_EXEC = 5'h02, ST_MEM = 5'h04, ST_WAIT = 5'h08, ST_CAP = 5'h10
  } caf_state_type;

endpackage : caf_pkg
`default_nettype wire

// ### sim/caf_checker.sv
// Port assertions of the operand and flag unit.
`default_nettype none
module caf_checker
  import caf_pkg::*;
(
  input wire logic CLK, RESETN, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID,
  input wire logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARVALID, S_AXI_ARREADY,
  input wire logic S_AXI_RVALID, S_AXI_RREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire caf_mem_req_type MEM_REQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Operand and fetch bytes come from rising addresses.
  property p_step; MEM_REQ.rd ##3 MEM_REQ.rd |-> MEM_REQ.addr == $past(MEM_REQ.addr, 3) + 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("byte step");
  property p_rdp; MEM_REQ.rd |=> !MEM_REQ.rd ##1 !MEM_REQ.rd; endproperty
  a_rdp: assert property (p_rdp) else $error("read pulse");
  property p_one; !(MEM_REQ.rd && MEM_REQ.wr); endproperty
  a_one: assert property (p_one) else $error("rd with wr");
  property p_bw; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_bw: assert property (p_bw) else $error("late write");
  property p_rv; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
  a_rv: assert property (p_rv) else $error("late read");
  property p_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read dropped");
  property p_bad; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= 8'h20
    |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("hole read");
  property p_ok; S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR < 8'h20 |=> S_AXI_RRESP == 2'h0;
  endproperty
  a_ok: assert property (p_ok) else $error("good read");
  c_rd: cover property (MEM_REQ.rd ##3 MEM_REQ.rd);
  c_wr: cover property (MEM_REQ.wr);
  c_bad: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
endmodule : caf_checker
bind caf_operand_unit caf_checker u_caf_checker (.*);
`default_nettype wire

// ### sim/caf_mem_model.sv
// Byte memory on the far side of the operand unit.
`default_nettype none
module caf_mem_model
  import caf_pkg::*;
(
  input wire logic CLK,
  input wire caf_mem_req_type MEM_REQ,
  output logic [7:0] MEM_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [65536];
  logic [7:0] q = 8'hA5;
  assign MEM_RDATA = q;
  // Read data stands one cycle, then flips so a late sample never matches.
  always @(posedge CLK) begin
    if (MEM_REQ.wr) mem[MEM_REQ.addr] <= MEM_REQ.wdata;
    q <= MEM_REQ.rd ? mem[MEM_REQ.addr] : ~q;
  end
endmodule : caf_mem_model
`default_nettype wire

// ### sim/caf_operand_unit_tb_top.sv
// Self-checking bench of the operand and flag unit.
`default_nettype none
module caf_operand_unit_tb_top
  import caf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
  logic [7:0] awa, ara, mrd;
  logic [31:0] wd, rdat, d;
  logic [1:0] br, rr, r;
  logic [39:0] row [8];
  caf_mem_req_type req;
  int fails = 0, comparisons = 0;
  caf_operand_unit u_caf_operand_unit (.CLK(clk), .RESETN(rstn), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .MEM_REQ(req), .MEM_RDATA(mrd));
  caf_mem_model u_caf_mem_model (.CLK(clk), .MEM_REQ(req), .MEM_RDATA(mrd));
  // Clock of 50 ns and a watchdog far past the run.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #500000;
    fails++;
    give_verdict();
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  // Bus write: address and data held until each is taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ad = 1'b0, dd = 1'b0;
    @(posedge clk);
    {awa, wd, awv, wv, bry} <= {a, v, 3'b111};
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awr) ad = 1'b1;
      if (wrd) dd = 1'b1;
      awv <= awv && !awr;
      wv <= wv && !wrd;
    end
    while (!bv) @(posedge clk);
    chk(32'h0, {30'h0, br});
    bry <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'b11};
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    {d, r} = {rdat, rr};
    rry <= 1'b0;
  endtask : axr
  // Start a command, then poll until busy drops.
  task automatic run(input logic [31:0] c);
    axw(8'h00, c);
    do axr(8'h04); while (d[8] !== 1'b0);
  endtask : run
  task automatic give_verdict();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Rows: accumulator, operand, op, result, flags.
  initial begin
    {rstn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
    row = '{40'h3AC600000F, 40'h1001020F02, 40'hF08F048010, 40'h555505000A,
      40'h0102060302, 40'h0506070513, 40'h1020013100, 40'h1001030F02};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    axr(8'h0C);
    chk(32'h0, d);
    foreach (row[i]) begin
      axw(8'h18, {8'h00, row[i][39:32], 16'h0000});
      axw(8'h08, {16'h0000, row[i][31:24], 8'h00});
      run({19'h0, row[i][18:16], 10'h016});
      axr(8'h18);
      chk({8'h00, row[i][15:8], 16'h0000}, d);
      axr(8'h04);
      chk({27'h0, row[i][4:0]}, d);
    end
    {u_caf_mem_model.mem[16'h2000], u_caf_mem_model.mem[16'h2001]} = 16'hC334;
    {u_caf_mem_model.mem[16'h2002], u_caf_mem_model.mem[16'h1234]} = 16'h125A;
    axw(8'h0C, 32'h0000_2000);
    run(32'h0000_6001);
    axr(8'h08);
    chk(32'h0012_34C3, d);
    axr(8'h0C);
    chk(32'h0000_2003, d);
    run(32'h0000_00E2);
    axr(8'h18);
    chk(32'h005A_0000, d);
    axw(8'h14, 32'h1122_0000);
    run(32'h0000_8003);
    chk(32'h1122, {16'h0, u_caf_mem_model.mem[16'h1235], u_caf_mem_model.mem[16'h1234]});
    for (int n = 0; n < 8; n++) begin
      axw(8'h08, {24'h0, 2'b11, n[2:0], 3'b111});
      run(32'h0000_0015);
      axr(8'h0C);
      chk({26'h0, n[2:0], 3'h0}, d);
    end
    u_caf_mem_model.mem[16'h5678] = 8'h9C;
    axw(8'h08, 32'h0056_7800);
    run(32'h0000_8204);
    axr(8'h18);
    chk(32'h005A_5678, d);
    run(32'h0000_02EA);
    axr(8'h18);
    chk(32'h009C_5678, d);
    run(32'h0000_0005);
    axr(8'h0C);
    chk(32'h0000_5678, d);
    run(32'h0000_000D);
    axr(8'h0C);
    chk(32'h0000_1122, d);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    axr(8'h0C);
    chk(32'h0, d);
    axw(8'h04, 32'h0000_001F);
    axr(8'h04);
    chk(32'h1F, d);
    axr(8'h20);
    chk(32'h2, {d[29:0], r});
    give_verdict();
  end
endmodule : caf_operand_unit_tb_top
`default_nettype wire
